// [hdl/mmu_pkg.sv]
package mmu_pkg;

	// ------------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------------
	localparam int unsigned WAYS   = 4;
	localparam int unsigned WAY_W  = 2;
	localparam int unsigned SETS   = 32;
	localparam int unsigned IDX_W  = 5;
	localparam int unsigned VPN_W  = 22;  // virtual address bits 31..10
	localparam int unsigned PROCESS_SPACE_ID_W = 8;
	localparam int unsigned PPN_W  = 22;  // physical address bits 31..10

	// ------------------------------------------------------------------
	// register byte offsets (low address byte)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS      = 8'h00;
	localparam logic [7:0] OFS_SAVED_STAT  = 8'h04;
	localparam logic [7:0] OFS_SAVED_PC    = 8'h08;
	localparam logic [7:0] OFS_EVENT_CODE  = 8'h0c;
	localparam logic [7:0] OFS_VECTOR_BASE = 8'h10;
	localparam logic [7:0] OFS_MMU_CONTROL = 8'he0;
	localparam logic [7:0] OFS_PAGE_HIGH   = 8'hf0;
	localparam logic [7:0] OFS_PAGE_LOW    = 8'hf4;
	localparam logic [7:0] OFS_FAULT_ADDR  = 8'hfc;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int unsigned CTL_ON     = 0;   // mmu_on_flag
	localparam int unsigned CTL_FLUSH  = 2;   // flush_bit, reads zero
	localparam int unsigned CTL_WAY_LO = 4;   // way_select_counter [5:4]
	localparam int unsigned CTL_SPACE  = 8;   // single_space_mode
	localparam int unsigned CTL_HASH   = 9;   // index_hash_enable
	localparam int unsigned ST_PRIV    = 30;  // privilege_flag
	localparam int unsigned ST_BANK    = 29;  // bank_select_flag
	localparam int unsigned ST_MASK    = 28;  // exception_mask_flag
	localparam int unsigned PL_VALID   = 8;
	localparam int unsigned PL_KEY_LO  = 5;   // access_key [6:5]
	localparam int unsigned PL_SIZE    = 4;   // page_size_flag, 1 = large
	localparam int unsigned PL_CACHE   = 3;
	localparam int unsigned PL_DIRTY   = 2;
	localparam int unsigned PL_GLOBAL  = 1;   // global_page_flag
	localparam int unsigned PAGE_LO    = 10;  // lowest page number bit

	// ------------------------------------------------------------------
	// codes, vectors, regions
	// ------------------------------------------------------------------
	localparam logic [11:0] CODE_MISS_LOAD  = 12'h040;
	localparam logic [11:0] CODE_MISS_STORE = 12'h060;
	localparam logic [31:0] MISS_VEC_OFS    = 32'h00000400;
	localparam logic [31:0] PHYS_MASK       = 32'h1fffffff;
	localparam logic [2:0]  REGION_UPPER    = 3'b110;  // mapped_upper_region
	localparam logic [2:0]  REGION_UNCACHED = 3'b101;  // unmapped_uncached_region
	localparam logic [2:0]  REGION_CTRL     = 3'b111;

	typedef enum logic [1:0] {
		EXC_MISS        = 2'b00,
		EXC_PROTECT     = 2'b01,
		EXC_INVALID     = 2'b10,
		EXC_FIRST_WRITE = 2'b11
	} exc_kind_t;

endpackage : mmu_pkg

// [hdl/tlb_miss_and_entry_load.sv]
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module tlb_miss_and_entry_load
	import mmu_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic [31:0]      HRDATA,
	input  wire logic        LOAD_ENTRY,
	input  wire logic        XLATE_REQ,
	input  wire logic [31:0] XLATE_VADDR,
	input  wire logic        XLATE_WRITE,
	input  wire logic [31:0] XLATE_PC,
	input  wire logic        XLATE_IN_SLOT,
	input  wire logic [31:0] XLATE_BRANCH_PC,
	output logic             XLATE_DONE,
	output logic [31:0]      XLATE_PADDR,
	output logic             XLATE_CACHEABLE,
	output logic [6:0]       CACHE_INDEX,
	output logic [21:0]      CACHE_TAG,
	output logic             EXC_TAKEN,
	output logic [1:0]       EXC_KIND,
	output logic [31:0]      EXC_VECTOR
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [31:0]      status_q;
	logic [31:0]      saved_status_q;
	logic [31:0]      saved_pc_q;
	logic [11:0]      event_code_q;
	logic [31:0]      vector_base_q;
	logic [31:0]      fault_addr_q;
	logic [VPN_W-1:0] page_vpn_q;
	logic [PROCESS_SPACE_ID_W-1:0] page_process_space_id_q;
	logic [31:0]      page_low_q;
	logic             on_q;
	logic             space_q;
	logic             hash_q;
	logic [WAY_W-1:0] way_sel_q;
	logic             wr_pend_q;
	logic [7:0]       wr_addr_q;
	logic [31:0]      rdata_q;
	logic             done_q;
	logic [31:0]      paddr_q;
	logic             cacheable_q;
	logic             exc_q;
	exc_kind_t        kind_q;
	logic [31:0]      vector_q;

	logic             bus_we;
	logic             flush;
	logic [IDX_W-1:0] load_idx;
	logic [IDX_W-1:0] look_idx;
	logic             skip_process_space_id;
	logic             mapped;
	logic             region_cached;
	logic [WAYS-1:0]  way_match;
	logic [WAYS-1:0]  way_valid;
	logic [PPN_W-1:0] way_ppn  [WAYS];
	logic [6:0]       way_info [WAYS];
	logic [WAY_W-1:0] hit_way;
	logic [WAY_W-1:0] free_way;
	logic             any_match;
	logic [6:0]       hit_info;
	logic             exc_now;
	logic             miss_now;
	exc_kind_t        kind_now;
	logic [31:0]      paddr_now;
	logic             cache_now;
	logic [31:0]      rd_mux;

	// ------------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------------
	// zero wait states; every access answers OKAY
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	assign HRDATA    = rdata_q;
	assign bus_we    = wr_pend_q;

	// address phase capture; read data latched here for the data phase
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q   <= 32'h00000000;
		end else if (HSEL && HREADY && HTRANS[1]) begin
			wr_pend_q <= HWRITE;
			wr_addr_q <= HADDR[7:0];
			rdata_q   <= HWRITE ? 32'h00000000 : rd_mux;
		end else begin
			wr_pend_q <= 1'b0;
		end
	end

	// read decode; unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (HADDR[7:0])
			OFS_STATUS:      rd_mux = status_q;
			OFS_SAVED_STAT:  rd_mux = saved_status_q;
			OFS_SAVED_PC:    rd_mux = saved_pc_q;
			OFS_EVENT_CODE:  rd_mux = {20'h00000, event_code_q};
			OFS_VECTOR_BASE: rd_mux = vector_base_q;
			OFS_MMU_CONTROL: begin
				rd_mux[CTL_ON]                    = on_q;
				rd_mux[CTL_WAY_LO+:WAY_W]         = way_sel_q;
				rd_mux[CTL_SPACE]                 = space_q;
				rd_mux[CTL_HASH]                  = hash_q;
			end
			OFS_PAGE_HIGH:   rd_mux = {page_vpn_q, 2'b00, page_process_space_id_q};
			OFS_PAGE_LOW:    rd_mux = page_low_q;
			OFS_FAULT_ADDR:  rd_mux = fault_addr_q;
			default:         rd_mux = 32'h00000000;
		endcase
	end

	// ------------------------------------------------------------------
	// ways and index
	// ------------------------------------------------------------------
	assign flush     = bus_we && wr_addr_q == OFS_MMU_CONTROL && HWDATA[CTL_FLUSH];
	assign load_idx  = hash_q ? (page_vpn_q[6:2] ^ page_process_space_id_q[IDX_W-1:0])
		: page_vpn_q[6:2];
	assign look_idx  = hash_q ? (XLATE_VADDR[16:12] ^ page_process_space_id_q[IDX_W-1:0])
		: XLATE_VADDR[16:12];
	assign skip_process_space_id = space_q && status_q[ST_PRIV];

	genvar g;
	generate
		for (g = 0; g < WAYS; g++) begin : g_way
			tlb_way u_way (
				.clk       (CLK),
				.rstn      (RSTN),
				.flush     (flush),
				.wr_en     (LOAD_ENTRY && way_sel_q == WAY_W'(g)),
				.wr_idx    (load_idx),
				.wr_vpn    (page_vpn_q),
				.wr_process_space_id   (page_process_space_id_q),
				.wr_ppn    (page_low_q[31:PAGE_LO]),
				.wr_info   ({page_low_q[PL_KEY_LO+:2], page_low_q[PL_SIZE], page_low_q[PL_CACHE],
					page_low_q[PL_DIRTY], page_low_q[PL_GLOBAL], page_low_q[PL_VALID]}),
				.rd_idx    (look_idx),
				.cmp_vpn   (XLATE_VADDR[31:PAGE_LO]),
				.cmp_process_space_id  (page_process_space_id_q),
				.skip_process_space_id (skip_process_space_id),
				.match     (way_match[g]),
				.valid     (way_valid[g]),
				.physical_frame_number       (way_ppn[g]),
				.info      (way_info[g])
			);
		end
	endgenerate

	// pick the lowest matching way and the lowest invalid way
	always_comb begin
		hit_way  = '0;
		free_way = '0;
		for (int w = WAYS - 1; w >= 0; w--) begin
			if (way_match[w]) begin
				hit_way = WAY_W'(w);
			end
			if (!way_valid[w]) begin
				free_way = WAY_W'(w);
			end
		end
	end

	// ------------------------------------------------------------------
	// translation check
	// ------------------------------------------------------------------
	assign any_match     = |way_match;
	assign hit_info      = way_info[hit_way];
	assign mapped        = !XLATE_VADDR[31] || XLATE_VADDR[31:29] == REGION_UPPER;
	assign region_cached = XLATE_VADDR[31:29] != REGION_UNCACHED
		&& XLATE_VADDR[31:29] != REGION_CTRL;

	// info layout: key[6:5] size[4] cache[3] dirty[2] global[1] valid[0]
	always_comb begin
		kind_now = EXC_MISS;
		if (!any_match) begin
			kind_now = EXC_MISS;
		end else if (!way_valid[hit_way]) begin
			kind_now = EXC_INVALID;
		end else if ((!status_q[ST_PRIV] && !hit_info[6]) || (XLATE_WRITE && !hit_info[5])) begin
			kind_now = EXC_PROTECT;
		end else if (XLATE_WRITE && !hit_info[2]) begin
			kind_now = EXC_FIRST_WRITE;
		end
	end

	// a valid matching entry with allowed access and, on a write, the dirty bit set is a hit
	assign exc_now  = XLATE_REQ && on_q && mapped
		&& !(any_match && way_valid[hit_way] && kind_now == EXC_MISS
		&& !((!status_q[ST_PRIV] && !hit_info[6]) || (XLATE_WRITE && !hit_info[5]))
		&& !(XLATE_WRITE && !hit_info[2]));
	assign miss_now = exc_now && kind_now == EXC_MISS;

	// untranslated access strips the region bits; large pages keep 12 offset bits
	// a miss has no entry to read, so it falls back to the stripped address
	always_comb begin
		paddr_now = XLATE_VADDR & PHYS_MASK;
		cache_now = region_cached;
		if (on_q && mapped && any_match) begin
			cache_now = hit_info[3];
			if (hit_info[4]) begin
				paddr_now = {way_ppn[hit_way][PPN_W-1:2], XLATE_VADDR[11:0]};
			end else begin
				paddr_now = {way_ppn[hit_way], XLATE_VADDR[PAGE_LO-1:0]};
			end
		end
	end

	// response registered one edge after the request
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			done_q      <= 1'b0;
			paddr_q     <= 32'h00000000;
			cacheable_q <= 1'b0;
			exc_q       <= 1'b0;
			kind_q      <= EXC_MISS;
			vector_q    <= 32'h00000000;
		end else begin
			done_q      <= XLATE_REQ;
			paddr_q     <= XLATE_REQ ? paddr_now : paddr_q;
			cacheable_q <= XLATE_REQ && !exc_now && cache_now;
			exc_q       <= exc_now;
			kind_q      <= exc_now ? kind_now : kind_q;
			vector_q    <= miss_now ? vector_base_q + MISS_VEC_OFS : vector_q;
		end
	end

	assign XLATE_DONE      = done_q;
	assign XLATE_PADDR     = paddr_q;
	assign XLATE_CACHEABLE = cacheable_q;
	assign CACHE_INDEX     = XLATE_VADDR[10:4];
	assign CACHE_TAG       = paddr_q[31:PAGE_LO];
	assign EXC_TAKEN       = exc_q;
	assign EXC_KIND        = kind_q;
	assign EXC_VECTOR      = vector_q;

	// ------------------------------------------------------------------
	// software-visible registers; hardware update wins over a bus write
	// ------------------------------------------------------------------
	// mmu_control: flush bit is a pulse and is never stored
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			on_q      <= 1'b0;
			space_q   <= 1'b0;
			hash_q    <= 1'b0;
			way_sel_q <= '0;
		end else begin
			if (bus_we && wr_addr_q == OFS_MMU_CONTROL) begin
				on_q    <= HWDATA[CTL_ON];
				space_q <= HWDATA[CTL_SPACE];
				hash_q  <= HWDATA[CTL_HASH];
			end
			if (miss_now) begin
				way_sel_q <= (&way_valid) ? way_sel_q + 1'b1 : free_way;
			end else if (bus_we && wr_addr_q == OFS_MMU_CONTROL) begin
				way_sel_q <= HWDATA[CTL_WAY_LO+:WAY_W];
			end
		end
	end

	// page_entry_high: every MMU exception drops the faulting page in
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			page_vpn_q  <= '0;
			page_process_space_id_q <= '0;
		end else if (exc_now) begin
			page_vpn_q <= XLATE_VADDR[31:PAGE_LO];
		end else if (bus_we && wr_addr_q == OFS_PAGE_HIGH) begin
			page_vpn_q  <= HWDATA[31:PAGE_LO];
			page_process_space_id_q <= HWDATA[PROCESS_SPACE_ID_W-1:0];
		end
	end

	// page_entry_low changes only by software
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			page_low_q <= 32'h00000000;
		end else if (bus_we && wr_addr_q == OFS_PAGE_LOW) begin
			page_low_q <= HWDATA;
		end
	end

	// miss capture of address, code and pc
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			fault_addr_q <= 32'h00000000;
			event_code_q <= 12'h000;
			saved_pc_q   <= 32'h00000000;
		end else if (miss_now) begin
			fault_addr_q <= XLATE_VADDR;
			event_code_q <= XLATE_WRITE ? CODE_MISS_STORE : CODE_MISS_LOAD;
			saved_pc_q   <= XLATE_IN_SLOT ? XLATE_BRANCH_PC : XLATE_PC;
		end else if (bus_we) begin
			if (wr_addr_q == OFS_FAULT_ADDR) begin
				fault_addr_q <= HWDATA;
			end
			if (wr_addr_q == OFS_EVENT_CODE) begin
				event_code_q <= HWDATA[11:0];
			end
			if (wr_addr_q == OFS_SAVED_PC) begin
				saved_pc_q <= HWDATA;
			end
		end
	end

	// status_word and its copy; the copy takes the value before modification
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			status_q       <= 32'h00000000;
			saved_status_q <= 32'h00000000;
			vector_base_q  <= 32'h00000000;
		end else begin
			if (miss_now) begin
				saved_status_q <= status_q;
				status_q       <= status_q | (32'h00000001 << ST_PRIV)
					| (32'h00000001 << ST_MASK) | (32'h00000001 << ST_BANK);
			end else if (bus_we && wr_addr_q == OFS_STATUS) begin
				status_q <= HWDATA;
			end else if (bus_we && wr_addr_q == OFS_SAVED_STAT) begin
				saved_status_q <= HWDATA;
			end
			if (bus_we && wr_addr_q == OFS_VECTOR_BASE) begin
				vector_base_q <= HWDATA;
			end
		end
	end

endmodule : tlb_miss_and_entry_load

// [hdl/tlb_way.sv]
`timescale 1ns/1ps
module tlb_way
	import mmu_pkg::*;
#(
	parameter int unsigned NSETS = SETS,
	parameter int unsigned IW    = IDX_W
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              flush,
	input  wire logic              wr_en,
	input  wire logic [IW-1:0]     wr_idx,
	input  wire logic [VPN_W-1:0]  wr_vpn,
	input  wire logic [PROCESS_SPACE_ID_W-1:0] wr_process_space_id,
	input  wire logic [PPN_W-1:0]  wr_ppn,
	input  wire logic [6:0]        wr_info,  // key[6:5] size cache dirty global valid
	input  wire logic [IW-1:0]     rd_idx,
	input  wire logic [VPN_W-1:0]  cmp_vpn,
	input  wire logic [PROCESS_SPACE_ID_W-1:0] cmp_process_space_id,
	input  wire logic              skip_process_space_id,
	output logic                   match,
	output logic                   valid,
	output logic [PPN_W-1:0]       physical_frame_number,
	output logic [6:0]             info
);

	logic [NSETS-1:0] valid_q;
	logic [NSETS-1:0] loaded_q;
	logic [VPN_W-1:0]  vpn_mem  [NSETS];
	logic [PROCESS_SPACE_ID_W-1:0] process_space_id_mem [NSETS];
	logic [PPN_W-1:0]  ppn_mem  [NSETS];
	logic [6:0]        info_mem [NSETS];
	logic              big;
	logic              shared;

	// valid bits need reset, so they live apart from the data arrays
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			valid_q <= '0;
		end else if (flush) begin
			valid_q <= '0;
		end else if (wr_en) begin
			valid_q[wr_idx] <= wr_info[0];
		end
	end

	// a slot never loaded holds no defined page, so it must never match;
	// a flush leaves it loaded so a stale page still reports invalid
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			loaded_q <= '0;
		end else if (wr_en) begin
			loaded_q[wr_idx] <= 1'b1;
		end
	end

	// entry contents, overwritten as a whole on load
	always_ff @(posedge clk) begin
		if (wr_en) begin
			vpn_mem[wr_idx]  <= wr_vpn;
			process_space_id_mem[wr_idx] <= wr_process_space_id;
			ppn_mem[wr_idx]  <= wr_ppn;
			info_mem[wr_idx] <= wr_info;
		end
	end

	// compare; small-page bits only matter for small pages
	assign big    = info_mem[rd_idx][PL_SIZE];
	assign shared = info_mem[rd_idx][PL_GLOBAL];
	assign match  = loaded_q[rd_idx]
		&& (vpn_mem[rd_idx][VPN_W-1:2] == cmp_vpn[VPN_W-1:2])
		&& (big || vpn_mem[rd_idx][1:0] == cmp_vpn[1:0])
		&& (shared || skip_process_space_id || process_space_id_mem[rd_idx] == cmp_process_space_id);
	assign valid  = valid_q[rd_idx];
	assign physical_frame_number    = ppn_mem[rd_idx];
	assign info   = info_mem[rd_idx];

endmodule : tlb_way

// [testbench/cpu_model.sv]
`timescale 1ns/1ps
module cpu_model (
	input  wire logic   clk,
	output logic        req,
	output logic [31:0] vaddr,
	output logic        wr,
	output logic        slot,
	output logic [31:0] pc,
	output logic [31:0] bpc,
	output logic        le
);
	// ----------
	// pipeline side
	// ----------
	// idle pipeline at time zero
	initial begin
		req = 1'b0;
		vaddr = 32'h0;
		wr = 1'b0;
		slot = 1'b0;
		pc = 32'h0;
		bpc = 32'h0;
		le = 1'b0;
	end
	// one access for one edge; the branch sits just before its slot
	task automatic xl(input logic [31:0] va, input logic w, input logic s,
		input logic [31:0] p);
		req <= 1'b1;
		vaddr <= va;
		wr <= w;
		slot <= s;
		pc <= p;
		bpc <= p - 32'h2;
		@(posedge clk);
		req <= 1'b0;
		vaddr <= ~va; // stale address is not kept on the lines
	endtask : xl
	// handler loads only after page_entry_low is set, then spends one
	// spare cycle so no translated access follows directly
	task automatic ld;
		le <= 1'b1;
		@(posedge clk);
		le <= 1'b0;
		@(posedge clk);
	endtask : ld
endmodule : cpu_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top
	import mmu_pkg::*;
;
	logic        clk, rstn, hsel, hwrite, rdy, resp, done, cach, exc;
	logic        req, wr, slot, le;
	logic [1:0]  htrans, kind;
	logic [31:0] haddr, hwdata, hrdata, pa, vec, r, va, pc, bpc;
	logic [6:0]  cidx;
	logic [21:0] ctag;
	int          n_fail, cmp_count;

	tlb_miss_and_entry_load i_tlb_miss_and_entry_load (
		.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(rdy),
		.HREADYOUT(rdy), .HRESP(resp), .HRDATA(hrdata), .LOAD_ENTRY(le),
		.XLATE_REQ(req), .XLATE_VADDR(va), .XLATE_WRITE(wr), .XLATE_PC(pc),
		.XLATE_IN_SLOT(slot), .XLATE_BRANCH_PC(bpc), .XLATE_DONE(done),
		.XLATE_PADDR(pa), .XLATE_CACHEABLE(cach), .CACHE_INDEX(cidx),
		.CACHE_TAG(ctag), .EXC_TAKEN(exc), .EXC_KIND(kind), .EXC_VECTOR(vec));
	cpu_model i_cpu_model (.clk(clk), .req(req), .vaddr(va), .wr(wr),
		.slot(slot), .pc(pc), .bpc(bpc), .le(le));

	// ----------
	// helpers
	// ----------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one single transfer; waits on hready rather than assuming zero wait
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'hffffff, a};
		hwrite <= w;
		do @(posedge clk); while (rdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(r, e);
	endtask : rc
	// outputs are read 1 ns after the answering edge, once settled
	task automatic tr(input logic [31:0] v, input logic w, input logic s,
		input logic [31:0] e, input logic x);
		i_cpu_model.xl(v, w, s, 32'h200);
		#1;
		chk({31'h0, done}, 32'h1);
		chk({31'h0, exc}, {31'h0, x});
		if (!x) begin
			chk(pa, e);
		end
	endtask : tr
	task automatic tdone(input int n);
		$display("test %0d finished", n);
	endtask : tdone
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up

	// ----------
	// clock, watchdog
	// ----------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// whole run is well under 1000 cycles
	initial begin
		#20000;
		n_fail++;
		wrap_up;
	end

	// ----------
	// tests
	// ----------
	initial begin
		rstn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwdata = 32'h0;
		n_fail = 0;
		cmp_count = 0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rc(OFS_MMU_CONTROL, 32'h0);
		tr(32'h00012c34, 1'b0, 1'b0, 32'h00012c34, 1'b0);
		bus(1'b1, 8'h40, 32'h5);
		rc(8'h40, 32'h0);
		tdone(1);
		bus(1'b1, OFS_VECTOR_BASE, 32'h80000000);
		bus(1'b1, OFS_MMU_CONTROL, 32'h5);
		tr(32'ha0001234, 1'b0, 1'b0, 32'h00001234, 1'b0);
		chk({31'h0, cach}, 32'h0);
		tr(32'h00012c34, 1'b0, 1'b0, 32'h0, 1'b1);
		chk({30'h0, kind}, {30'h0, EXC_MISS});
		chk(vec, 32'h80000400);
		rc(OFS_PAGE_HIGH, 32'h00012c00);
		rc(OFS_FAULT_ADDR, 32'h00012c34);
		rc(OFS_EVENT_CODE, 32'h40);
		rc(OFS_SAVED_PC, 32'h200);
		rc(OFS_SAVED_STAT, 32'h0);
		rc(OFS_STATUS, 32'h70000000);
		rc(OFS_MMU_CONTROL, 32'h1);
		tdone(2);
		bus(1'b1, OFS_STATUS, 32'h40000000);
		tr(32'h00000800, 1'b1, 1'b1, 32'h0, 1'b1);
		rc(OFS_EVENT_CODE, 32'h60);
		rc(OFS_SAVED_PC, 32'h1fe);
		rc(OFS_SAVED_STAT, 32'h40000000);
		tdone(3);
		// fill every way of index 0x12; counter left at three
		for (int w = 0; w < 4; w++) begin
			bus(1'b1, OFS_MMU_CONTROL, 32'h1 | (w << 4));
			bus(1'b1, OFS_PAGE_HIGH, (w << 20) | 32'h12000);
			bus(1'b1, OFS_PAGE_LOW, ((32'h100 + w) << 10) | 32'h16c);
			i_cpu_model.ld;
		end
		for (int w = 0; w < 4; w++) begin
			tr((w << 20) | 32'h12345, 1'b0, 1'b0, ((32'h100 + w) << 10) | 32'h345, 1'b0);
			chk({31'h0, cach}, 32'h1);
		end
		tr(32'h00f12000, 1'b0, 1'b0, 32'h0, 1'b1);
		rc(OFS_MMU_CONTROL, 32'h1);
		tdone(4);
		bus(1'b1, OFS_MMU_CONTROL, 32'h205);
		bus(1'b1, OFS_PAGE_HIGH, 32'h00040003);
		bus(1'b1, OFS_PAGE_LOW, 32'h0008016c);
		i_cpu_model.ld;
		tr(32'h00040010, 1'b0, 1'b0, 32'h00080010, 1'b0);
		bus(1'b1, OFS_MMU_CONTROL, 32'h1);
		tr(32'h00040010, 1'b0, 1'b0, 32'h0, 1'b1);
		bus(1'b1, OFS_PAGE_HIGH, 32'h00000000);
		tr(32'h00012345, 1'b0, 1'b0, 32'h0, 1'b1);
		chk({30'h0, kind}, {30'h0, EXC_INVALID});
		// large private page: bits 11..10 ignored, space id still compared
		bus(1'b1, OFS_PAGE_HIGH, 32'h00005001);
		bus(1'b1, OFS_PAGE_LOW, 32'h000c017c);
		i_cpu_model.ld;
		tr(32'h00005c34, 1'b0, 1'b0, 32'h000c0c34, 1'b0);
		bus(1'b1, OFS_PAGE_HIGH, 32'h00005002);
		tr(32'h00005c34, 1'b0, 1'b0, 32'h0, 1'b1);
		tdone(5);
		// protection, invalid entry, first write, each on a store
		for (int k = 1; k < 4; k++) begin
			bus(1'b1, OFS_MMU_CONTROL, 32'h1);
			bus(1'b1, OFS_PAGE_HIGH, 32'h00060000);
			bus(1'b1, OFS_PAGE_LOW, k == 1 ? 32'h10c : (k == 2 ? 32'h6c : 32'h168));
			i_cpu_model.ld;
			tr(32'h00060000, 1'b1, 1'b0, 32'h0, 1'b1);
			chk({30'h0, kind}, k);
		end
		bus(1'b1, OFS_MMU_CONTROL, 32'h0);
		tr(32'h00f12000, 1'b0, 1'b0, 32'h00f12000, 1'b0);
		tdone(6);
		wrap_up;
	end
endmodule : tb_top

// [testbench/tlb_monitor.sv]
`timescale 1ns/1ps
module tlb_monitor
	import mmu_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic        XLATE_REQ,
	input wire logic [31:0] XLATE_VADDR,
	input wire logic        XLATE_DONE,
	input wire logic [31:0] XLATE_PADDR,
	input wire logic        XLATE_CACHEABLE,
	input wire logic [6:0]  CACHE_INDEX,
	input wire logic [21:0] CACHE_TAG,
	input wire logic        EXC_TAKEN,
	input wire logic [1:0]  EXC_KIND
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// ----------
	// translation answer
	// ----------
	// addresses 0x8..-0xb.. bypass the table, so no fault may come back
	sequence s_unmapped;
		XLATE_REQ && XLATE_VADDR[31:30] == 2'b10;
	endsequence
	sequence s_clean;
		XLATE_DONE && !EXC_TAKEN;
	endsequence
	AST_DONE_NEXT: assert property (XLATE_REQ |=> XLATE_DONE)
		else $error("no done one cycle after request");
	AST_NO_STRAY_DONE: assert property (!XLATE_REQ |=> !XLATE_DONE)
		else $error("done without request");
	AST_UNMAPPED: assert property (s_unmapped |=> s_clean ##0
		XLATE_PADDR == ($past(XLATE_VADDR) & PHYS_MASK))
		else $error("unmapped address not passed through");
	AST_EXC_DONE: assert property (EXC_TAKEN |-> XLATE_DONE && !XLATE_CACHEABLE)
		else $error("fault outside answer or marked cacheable");
	AST_KIND_HOLD: assert property (!EXC_TAKEN |-> $stable(EXC_KIND))
		else $error("fault kind moved without fault");
	AST_PADDR_HOLD: assert property (!XLATE_DONE |-> $stable(XLATE_PADDR))
		else $error("physical address moved without answer");
	AST_CACHE_INDEX: assert property (CACHE_INDEX == XLATE_VADDR[10:4])
		else $error("cache index not virtual bits 10..4");
	AST_CACHE_TAG: assert property (CACHE_TAG == XLATE_PADDR[31:10])
		else $error("cache tag not physical bits 31..10");
endmodule : tlb_monitor

bind tlb_miss_and_entry_load tlb_monitor i_tlb_monitor (
	.CLK(CLK), .RSTN(RSTN), .XLATE_REQ(XLATE_REQ), .XLATE_VADDR(XLATE_VADDR),
	.XLATE_DONE(XLATE_DONE), .XLATE_PADDR(XLATE_PADDR),
	.XLATE_CACHEABLE(XLATE_CACHEABLE), .CACHE_INDEX(CACHE_INDEX),
	.CACHE_TAG(CACHE_TAG), .EXC_TAKEN(EXC_TAKEN), .EXC_KIND(EXC_KIND)
);
